/* File: verilog/standby_pkg.sv */
package standby_pkg;
   // command opcodes, two per command
   localparam logic [7:0] CMD_TIMED_A = 8'hE2;
   localparam logic [7:0] CMD_TIMED_B = 8'h96;
   localparam logic [7:0] CMD_NOW_A = 8'hE0;
   localparam logic [7:0] CMD_NOW_B = 8'h94;
   // timeout code ranges and fixed codes
   localparam logic [7:0] CODE_OFF = 8'h00;
   localparam logic [7:0] CODE_SHORT_LAST = 8'hF0;
   localparam logic [7:0] CODE_LONG_LAST = 8'hFB;
   localparam logic [7:0] CODE_21MIN = 8'hFC;
   localparam logic [7:0] CODE_8H = 8'hFD;
   localparam logic [7:0] CODE_RESERVED = 8'hFE;
   localparam logic [7:0] CODE_21MIN15 = 8'hFF;
   // timer width and interval figures in seconds
   localparam int TIMER_W = 16;
   localparam logic [15:0] STEP_SHORT_SEC = 16'h0005;
   localparam logic [15:0] STEP_LONG_SEC = 16'h0708;
   localparam logic [15:0] FIXED_21MIN_SEC = 16'h04EC;
   localparam logic [15:0] FIXED_8H_SEC = 16'h7080;
   localparam logic [15:0] FIXED_21MIN15_SEC = 16'h04FB;
   // one timer tick is one second
   localparam int TICK_MS = 1000;
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_CYCLES = TICK_MS * 1000000 / CLK_PERIOD_NS;
   // status and error bit positions
   localparam int ST_BSY = 7;
   localparam int ST_RDY = 6;
   localparam int ST_DSC = 4;
   localparam int ST_ERR = 0;
   localparam int ER_ABT = 2;
   // reset values
   localparam logic [7:0] STATUS_RST = 8'h50;
   localparam logic [7:0] ERROR_RST = 8'h00;
   // power states
   typedef enum logic [2:0] {PM_ACTIVE, PM_FLUSH, PM_SPINDOWN, PM_STANDBY, PM_SPINUP} pm_state_e;
endpackage

/* File: verilog/apm_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface apm_if;
   import standby_pkg::*;
   logic load;
   logic [7:0] code;
   logic restart;
   logic run;
   logic tick;
   logic expire;
   logic enabled;
   logic [TIMER_W-1:0] count;
   logic [TIMER_W-1:0] interval;
   modport ctrl (output load, code, restart, run, tick, input expire, enabled, count, interval);
   modport timer (input load, code, restart, run, tick, output expire, enabled, count, interval);
endinterface
`default_nettype wire

/* File: verilog/apm_timer.sv */
`timescale 1ns/100ps
`default_nettype none
module apm_timer
   import standby_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // control side
   apm_if.timer tmr
);
   logic [TIMER_W-1:0] dec;
   logic [TIMER_W-1:0] code16;
   logic [TIMER_W-1:0] next_count;
   logic [TIMER_W-1:0] next_interval;
   logic next_enabled;
   logic next_expire;

   // timeout code to seconds
   always_comb begin
      code16 = {8'h00, tmr.code};
      dec = 16'h0000;
      if (tmr.code == CODE_OFF) begin
         dec = 16'h0000; // [RULE6]
      end else if (tmr.code <= CODE_SHORT_LAST) begin
         dec = 16'(code16 * STEP_SHORT_SEC); // [RULE7] [RULE13]
      end else if (tmr.code <= CODE_LONG_LAST) begin
         dec = 16'((code16 - {8'h00, CODE_SHORT_LAST}) * STEP_LONG_SEC); // [RULE7] [RULE13]
      end else if (tmr.code == CODE_21MIN) begin
         dec = FIXED_21MIN_SEC; // [RULE8] [RULE13]
      end else if (tmr.code == CODE_8H) begin
         dec = FIXED_8H_SEC; // [RULE8] [RULE13]
      end else if (tmr.code == CODE_21MIN15) begin
         dec = FIXED_21MIN15_SEC; // [RULE8] [RULE13]
      end
   end

   // load, restart and count down
   always_comb begin
      next_interval = tmr.interval;
      next_enabled = tmr.enabled;
      next_count = tmr.count;
      next_expire = 1'b0;
      if (tmr.load) begin
         next_interval = dec;
         next_enabled = (tmr.code != CODE_OFF); // [RULE6]
         next_count = dec;
      end else if (!tmr.run || tmr.restart) begin
         next_count = tmr.interval; // [RULE5] [RULE10]
      end else if (tmr.tick && tmr.enabled && tmr.count != 16'h0000) begin
         next_count = tmr.count - 16'h0001;
         next_expire = (tmr.count == 16'h0001);
      end
   end

   // timer registers
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         tmr.interval <= 16'h0000;
         tmr.enabled <= 1'b0;
         tmr.count <= 16'h0000;
         tmr.expire <= 1'b0;
      end else begin
         tmr.interval <= next_interval;
         tmr.enabled <= next_enabled;
         tmr.count <= next_count;
         tmr.expire <= next_expire;
      end
   end

   property p_zero_disable;
      @(posedge clk_in) disable iff (!nrst_in) tmr.load && tmr.code == CODE_OFF |=> !tmr.enabled;
   endproperty
   a_zero_disable: assert property (p_zero_disable) else $error("zero code left timer on"); // [RULE6]

   property p_short_step;
      @(posedge clk_in) disable iff (!nrst_in)
         tmr.load && tmr.code == 8'h02 |=> tmr.count == 16'h000A && tmr.enabled;
   endproperty
   a_short_step: assert property (p_short_step) else $error("code 2 not 10 s"); // [RULE7]

   property p_long_step;
      @(posedge clk_in) disable iff (!nrst_in) tmr.load && tmr.code == 8'hF1 |=> tmr.count == 16'h0708;
   endproperty
   a_long_step: assert property (p_long_step) else $error("code 241 not half an hour"); // [RULE13]

   property p_fixed_codes;
      @(posedge clk_in) disable iff (!nrst_in)
         tmr.load && tmr.code == CODE_8H |=> tmr.interval == 16'h7080;
   endproperty
   a_fixed_codes: assert property (p_fixed_codes) else $error("code 253 not 8 h"); // [RULE8]

   property p_restart;
      @(posedge clk_in) disable iff (!nrst_in)
         !tmr.load && (tmr.restart || !tmr.run) |=> tmr.count == $past(tmr.interval);
   endproperty
   a_restart: assert property (p_restart) else $error("timer not reloaded"); // [RULE10]

   c_expire: cover property (@(posedge clk_in) disable iff (!nrst_in) tmr.expire);
endmodule // apm_timer
`default_nettype wire

/* File: verilog/standby_power_command_handler.sv */
`timescale 1ns/100ps
`default_nettype none
// Function
// (RULE1) timed standby opcodes enter standby and load the power-down timeout
// (RULE2) flush cached writes first, then stop spindle; interface stays active
// (RULE3) spindle already stopped: skip spin-down, just complete the command
// (RULE4) accept commands in standby; media access waits for spindle speed
// (RULE5) power-down countdown runs only after return to idle mode
// (RULE6) timeout code zero disables auto power-down, nonzero enables it
// (RULE7) codes give value times five, or value minus 240 times thirty minutes
// (RULE8) fixed codes: 21 minutes, 8 hours, reserved, 21 minutes 15 seconds
// (RULE9) interval elapsing without host access enters standby automatically
// (RULE10) any host access restarts the timer from its full interval
// (RULE11) immediate standby opcodes enter standby with same flush and spin-down
// (RULE12) immediate standby leaves the stored timeout unchanged
// (RULE13) codes 1-240 five-second steps, 241-251 half hours, 252-255 fixed
// (RULE14) failed standby ends with abort in error and error in status; a failed automatic power-down sets neither
module standby_power_command_handler
   import standby_pkg::*;
#(
   parameter int TICK_LEN = TICK_CYCLES
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // command from the host command decoder
   input wire logic cmd_valid_in,
   input wire logic [7:0] cmd_code_in,
   input wire logic [7:0] cmd_count_in,
   input wire logic host_access_in,
   // cache and spindle
   input wire logic flush_done_in,
   input wire logic flush_error_in,
   input wire logic spindle_stopped_in,
   input wire logic spindle_at_speed_in,
   input wire logic media_req_in,
   output logic flush_req_out,
   output logic spin_down_out,
   output logic spin_up_out,
   output logic media_grant_out,
   // command completion
   output logic done_out,
   output logic [7:0] status_out,
   output logic [7:0] error_out,
   output logic standby_out
);
   // the divider needs at least two cycles per tick
   if (TICK_LEN < 2) begin : g_tick_check
      $error("TICK_LEN must be at least 2");
   end

   apm_if tmr ();

   apm_timer u_timer (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .tmr(tmr)
   );

   pm_state_e state, next_state;
   logic [31:0] div, next_div;
   logic tick, next_tick;
   logic auto, next_auto;
   logic next_flush_req, next_spin_down, next_spin_up, next_grant;
   logic next_done, next_standby;
   logic [7:0] next_status, next_error;
   logic is_timed, is_now, accept;

   // one-second tick divider
   always_comb begin
      next_tick = 1'b0;
      next_div = div + 32'h00000001;
      if (div == 32'(TICK_LEN - 1)) begin
         next_div = 32'h00000000;
         next_tick = 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         div <= 32'h00000000;
         tick <= 1'b0;
      end else begin
         div <= next_div;
         tick <= next_tick;
      end
   end

   // command recognition; commands are taken in idle mode and in standby
   assign is_timed = (cmd_code_in == CMD_TIMED_A) || (cmd_code_in == CMD_TIMED_B);
   assign is_now = (cmd_code_in == CMD_NOW_A) || (cmd_code_in == CMD_NOW_B);
   assign accept = cmd_valid_in && (is_timed || is_now)
                   && (state == PM_ACTIVE || state == PM_STANDBY);

   // timer control
   assign tmr.load = accept && is_timed && (cmd_count_in != CODE_RESERVED); // [RULE1] [RULE12]
   assign tmr.code = cmd_count_in;
   assign tmr.restart = host_access_in; // [RULE10]
   assign tmr.run = (state == PM_ACTIVE); // [RULE5]
   assign tmr.tick = tick;

   // power state sequencing
   always_comb begin
      next_state = state;
      next_auto = auto;
      next_done = 1'b0;
      next_status = status_out;
      next_error = error_out;
      if (accept) begin
         next_status[ST_ERR] = 1'b0;
         next_error = ERROR_RST;
         next_auto = 1'b0;
      end
      case (state)
         PM_ACTIVE: begin
            if (accept && is_timed && cmd_count_in == CODE_RESERVED) begin
               next_done = 1'b1;
               next_status[ST_ERR] = 1'b1; // [RULE14]
               next_error[ER_ABT] = 1'b1; // [RULE14]
            end else if (accept && spindle_stopped_in) begin
               next_state = PM_STANDBY; // [RULE3]
               next_done = 1'b1;
            end else if (accept) begin
               next_state = PM_FLUSH; // [RULE1] [RULE11]
            end else if (tmr.expire && !host_access_in) begin
               next_state = PM_FLUSH; // [RULE9]
               next_auto = 1'b1;
            end
         end
         PM_FLUSH: begin
            if (flush_error_in) begin
               next_state = PM_ACTIVE;
               next_done = !auto;
               // an automatic power-down fails quietly and keeps the last report
               if (!auto) begin
                  next_status[ST_ERR] = 1'b1; // [RULE14]
                  next_error[ER_ABT] = 1'b1; // [RULE14]
               end
            end else if (flush_done_in) begin
               next_state = PM_SPINDOWN; // [RULE2]
            end
         end
         PM_SPINDOWN: begin
            if (spindle_stopped_in) begin
               next_state = PM_STANDBY;
               next_done = !auto;
            end
         end
         PM_STANDBY: begin
            if (accept && is_timed && cmd_count_in == CODE_RESERVED) begin
               next_done = 1'b1;
               next_status[ST_ERR] = 1'b1; // [RULE14]
               next_error[ER_ABT] = 1'b1;
            end else if (accept) begin
               next_done = 1'b1; // [RULE3]
            end else if (media_req_in) begin
               next_state = PM_SPINUP; // [RULE4]
            end
         end
         PM_SPINUP: begin
            if (spindle_at_speed_in) begin
               next_state = PM_ACTIVE; // [RULE4]
            end
         end
         default: begin
            next_state = PM_ACTIVE;
         end
      endcase
      next_flush_req = (next_state == PM_FLUSH); // [RULE2]
      next_spin_down = (next_state == PM_SPINDOWN); // [RULE2]
      next_spin_up = (next_state == PM_SPINUP);
      next_grant = (next_state == PM_ACTIVE); // [RULE4]
      next_standby = (next_state == PM_STANDBY);
      next_status[ST_BSY] = (next_state == PM_FLUSH || next_state == PM_SPINDOWN) && !next_auto;
      next_status[ST_RDY] = 1'b1; // interface stays active in standby
      next_status[ST_DSC] = 1'b1;
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state <= PM_ACTIVE;
         auto <= 1'b0;
         done_out <= 1'b0;
         status_out <= STATUS_RST;
         error_out <= ERROR_RST;
         flush_req_out <= 1'b0;
         spin_down_out <= 1'b0;
         spin_up_out <= 1'b0;
         media_grant_out <= 1'b1;
         standby_out <= 1'b0;
      end else begin
         state <= next_state;
         auto <= next_auto;
         done_out <= next_done;
         status_out <= next_status;
         error_out <= next_error;
         flush_req_out <= next_flush_req;
         spin_down_out <= next_spin_down;
         spin_up_out <= next_spin_up;
         media_grant_out <= next_grant;
         standby_out <= next_standby;
      end
   end

   property p_timed_load;
      @(posedge clk_in) disable iff (!nrst_in)
         accept && is_timed && cmd_count_in != CODE_RESERVED |-> tmr.load;
   endproperty
   a_timed_load: assert property (p_timed_load) else $error("timed standby did not load"); // [RULE1]

   property p_flush_first;
      @(posedge clk_in) disable iff (!nrst_in) $rose(spin_down_out) |-> $past(flush_req_out);
   endproperty
   a_flush_first: assert property (p_flush_first) else $error("spin-down before flush"); // [RULE2]

   property p_skip_spindown;
      @(posedge clk_in) disable iff (!nrst_in)
         accept && spindle_stopped_in && !(is_timed && cmd_count_in == CODE_RESERVED)
         |=> done_out && standby_out && !flush_req_out && !spin_down_out;
   endproperty
   a_skip_spindown: assert property (p_skip_spindown) else $error("stopped spindle not skipped"); // [RULE3]

   property p_media_wait;
      @(posedge clk_in) disable iff (!nrst_in)
         $rose(media_grant_out) && !$past(flush_req_out)
         |-> $past(spin_up_out) && $past(spindle_at_speed_in);
   endproperty
   a_media_wait: assert property (p_media_wait) else $error("media granted before speed"); // [RULE4]

   property p_auto_standby;
      @(posedge clk_in) disable iff (!nrst_in)
         state == PM_ACTIVE && tmr.expire && !host_access_in && !accept
         |=> flush_req_out && !done_out && !status_out[ST_BSY];
   endproperty
   a_auto_standby: assert property (p_auto_standby) else $error("expiry did not power down"); // [RULE9]

   property p_now_flush;
      @(posedge clk_in) disable iff (!nrst_in)
         accept && is_now && state == PM_ACTIVE && !spindle_stopped_in
         |=> flush_req_out && status_out[ST_BSY] && !media_grant_out;
   endproperty
   a_now_flush: assert property (p_now_flush) else $error("immediate standby no flush"); // [RULE11]

   property p_now_keeps;
      @(posedge clk_in) disable iff (!nrst_in) accept && is_now |-> !tmr.load;
   endproperty
   a_now_keeps: assert property (p_now_keeps) else $error("immediate standby loaded timer"); // [RULE12]

   property p_abort;
      @(posedge clk_in) disable iff (!nrst_in)
         accept && is_timed && cmd_count_in == CODE_RESERVED
         |=> done_out && error_out[ER_ABT] && status_out[ST_ERR];
   endproperty
   a_abort: assert property (p_abort) else $error("reserved code not aborted"); // [RULE14]

   c_timed: cover property (@(posedge clk_in) disable iff (!nrst_in) accept && is_timed);
   c_spinup: cover property (@(posedge clk_in) disable iff (!nrst_in) $fell(spin_up_out));
   c_flush_fail: cover property (@(posedge clk_in) disable iff (!nrst_in)
      flush_req_out && flush_error_in);
endmodule // standby_power_command_handler
`default_nettype wire

/* File: sim/spindle_model.sv */
`timescale 1ns/100ps
`default_nettype none
module spindle_model (
   // clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // requests from the block
   input wire logic flush_req_in,
   input wire logic spin_down_in,
   input wire logic spin_up_in,
   // scenario controls: answer delay and flush failure
   input wire logic [3:0] delay_in,
   input wire logic fail_in,
   // answers to the block
   output logic flush_done_out,
   output logic flush_error_out,
   output logic stopped_out,
   output logic at_speed_out
);
   logic [2:0] req;
   logic [2:0] req_q;
   logic answered;
   int wait_n;
   assign req = {flush_req_in, spin_down_in, spin_up_in};
   // answers each new request once, delay_in cycles later, off the falling edge
   always @(negedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         req_q = 3'h0;
         answered = 1'b0;
         wait_n = 0;
         flush_done_out = 1'b0;
         flush_error_out = 1'b0;
         stopped_out = 1'b0; // spindle runs out of reset
         at_speed_out = 1'b1;
      end else begin
         flush_done_out = 1'b0;
         flush_error_out = 1'b0;
         if (req != req_q) begin
            answered = 1'b0;
            wait_n = 0;
         end
         req_q = req;
         if (req == 3'h0 || answered) begin
            wait_n = 0;
         end else if (wait_n < int'(delay_in)) begin
            wait_n++;
         end else begin
            answered = 1'b1;
            if (flush_req_in) begin
               flush_error_out = fail_in;
               flush_done_out = !fail_in;
            end else begin
               stopped_out = spin_down_in; // spin-down stops, spin-up restarts
               at_speed_out = !spin_down_in;
            end
         end
      end
   end
endmodule // spindle_model
`default_nettype wire

/* File: sim/standby_power_command_handler_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module standby_power_command_handler_tb;
   import standby_pkg::*;
   localparam int T = 4;
   logic clk_in, nrst_in, cmd_valid, host_access, media_req, fail;
   logic [7:0] cmd_code, cmd_count, status, error;
   logic [3:0] dly;
   logic fl_done, fl_err, stopped, at_speed, fl_req, sp_down, sp_up, grant, done, stby;
   int mismatches, total_checks, cyc_n, fl_at, sd_at, n;
   standby_power_command_handler #(.TICK_LEN(T)) dut (.clk_in(clk_in), .nrst_in(nrst_in),
      .cmd_valid_in(cmd_valid), .cmd_code_in(cmd_code), .cmd_count_in(cmd_count),
      .host_access_in(host_access), .flush_done_in(fl_done), .flush_error_in(fl_err),
      .spindle_stopped_in(stopped), .spindle_at_speed_in(at_speed), .media_req_in(media_req),
      .flush_req_out(fl_req), .spin_down_out(sp_down), .spin_up_out(sp_up),
      .media_grant_out(grant), .done_out(done), .status_out(status), .error_out(error),
      .standby_out(stby));
   spindle_model partner (.clk_in(clk_in), .nrst_in(nrst_in), .flush_req_in(fl_req),
      .spin_down_in(sp_down), .spin_up_in(sp_up), .delay_in(dly), .fail_in(fail),
      .flush_done_out(fl_done), .flush_error_out(fl_err), .stopped_out(stopped),
      .at_speed_out(at_speed));
   // clock
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   // first cycles at which flush and spin-down were requested
   always @(negedge clk_in) begin
      cyc_n++;
      if (fl_req === 1'b1 && fl_at < 0) fl_at = cyc_n;
      if (sp_down === 1'b1 && sd_at < 0) sd_at = cyc_n;
   end
   task final_report;
      if (mismatches == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task compare(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task ran_out;
      mismatches++;
      $display("BAD %0t wait ran out", $time);
      final_report();
   endtask
   task send(input logic [7:0] c, input logic [7:0] k);
      @(negedge clk_in);
      fl_at = -1;
      sd_at = -1;
      cmd_code = c;
      cmd_count = k;
      cmd_valid = 1'b1;
      @(negedge clk_in);
      cmd_valid = 1'b0;
   endtask
   task wait_done(output int w);
      w = 0;
      while (done !== 1'b1) begin
         @(negedge clk_in);
         w++;
         if (w > 200) ran_out();
      end
   endtask
   // media request until the spindle is back and the media granted
   task wake;
      int w;
      w = 0;
      media_req = 1'b1;
      while (grant !== 1'b1) begin
         @(negedge clk_in);
         w++;
         if (w > 100) ran_out();
      end
      media_req = 1'b0;
   endtask
   // idle cycles until auto power-down starts, then quiet entry into standby
   task measure(input int secs);
      int w;
      logic ds;
      w = 0;
      ds = 1'b0;
      while (fl_req !== 1'b1) begin
         @(negedge clk_in);
         w++;
         if (w > 40000) ran_out();
      end
      compare({7'h00, w >= secs * T - T - 4 && w <= secs * T + T + 4}, 8'h01);
      w = 0;
      while (stby !== 1'b1) begin
         @(negedge clk_in);
         if (done === 1'b1) ds = 1'b1;
         w++;
         if (w > 100) ran_out();
      end
      compare({7'h00, ds}, 8'h00);
   endtask
   // reset values
   task t_reset;
      compare(status, STATUS_RST);
      compare(error, ERROR_RST);
      compare({7'h00, grant}, 8'h01);
   endtask
   // immediate standby with a slow partner: flush, spin-down, then done
   task t_now;
      send(CMD_NOW_A, 8'h00);
      compare({7'h00, status[ST_BSY]}, 8'h01);
      wait_done(n);
      compare({7'h00, stby}, 8'h01);
      compare({7'h00, fl_at > 0 && sd_at > fl_at}, 8'h01);
      compare(status, STATUS_RST);
   endtask
   // already spun down: done stands at the first sample after the command
   task t_stopped;
      send(CMD_NOW_B, 8'h00);
      wait_done(n);
      compare(n[7:0], 8'h00);
      compare({7'h00, sd_at < 0}, 8'h01);
   endtask
   // media access from standby waits for the spindle
   task t_media;
      media_req = 1'b1;
      repeat (2) @(negedge clk_in);
      compare({6'h00, sp_up, grant}, 8'h02);
      wake();
      compare({7'h00, stby}, 8'h00);
   endtask
   // reserved timeout code is aborted
   task t_reserved;
      send(CMD_TIMED_A, CODE_RESERVED);
      wait_done(n);
      compare(status, STATUS_RST | 8'h01);
      compare(error, 8'h04);
      compare({7'h00, stby}, 8'h00);
   endtask
   // failed flush is aborted
   task t_flush_fail;
      fail = 1'b1;
      send(CMD_NOW_B, 8'h00);
      wait_done(n);
      compare(error, 8'h04);
      compare(status, 8'h51);
      compare({7'h00, stby}, 8'h00);
      fail = 1'b0;
   endtask
   // immediate standby keeps the timeout, no countdown in standby
   task t_keep;
      send(CMD_NOW_A, 8'h00);
      wait_done(n);
      repeat (60) @(negedge clk_in);
      wake();
      measure(10);
   endtask
   // host access restarts the countdown
   task t_restart;
      wake();
      repeat (30) @(negedge clk_in);
      host_access = 1'b1;
      @(negedge clk_in);
      host_access = 1'b0;
      measure(10);
   endtask
   // eight-hour code outlasts every entry timed earlier in the run
   task t_8h;
      send(CMD_TIMED_A, CODE_8H);
      wait_done(n);
      wake();
      repeat (8000) @(negedge clk_in);
      compare({7'h00, fl_req}, 8'h00);
   endtask
   // code zero disables auto power-down
   task t_off;
      send(CMD_TIMED_B, CODE_OFF);
      wait_done(n);
      wake();
      repeat (400) @(negedge clk_in);
      compare({6'h00, fl_req, stby}, 8'h00);
   endtask
   task t_timed(input logic [7:0] c, input logic [7:0] k, input int secs);
      send(c, k);
      wait_done(n);
      compare({7'h00, stby}, 8'h01);
      wake();
      measure(secs);
   endtask
   // main sequence
   initial begin
      nrst_in = 1'b0;
      cmd_valid = 1'b0;
      cmd_code = 8'h00;
      cmd_count = 8'h00;
      host_access = 1'b0;
      media_req = 1'b0;
      fail = 1'b0;
      dly = 4'h6;
      mismatches = 0;
      total_checks = 0;
      cyc_n = 0;
      fl_at = -1;
      sd_at = -1;
      repeat (6) @(negedge clk_in);
      nrst_in = 1'b1;
      t_reset();
      t_now();
      t_stopped();
      t_media();
      t_reserved();
      t_flush_fail();
      dly = 4'h0;
      // timeout codes, both ranges and fixed entries
      t_timed(CMD_TIMED_A, 8'h01, 5);
      t_timed(CMD_TIMED_B, CODE_SHORT_LAST, 1200);
      t_timed(CMD_TIMED_A, 8'hF1, 1800);
      t_timed(CMD_TIMED_B, CODE_21MIN, 1260);
      t_timed(CMD_TIMED_A, CODE_21MIN15, 1275);
      t_timed(CMD_TIMED_A, 8'h02, 10);
      t_keep();
      t_restart();
      t_8h();
      t_off();
      final_report();
   end
endmodule // standby_power_command_handler_tb
`default_nettype wire
